// ===== rtl/emh_centre.sv
/*
 * centre-side modem protocol control: start/resend requests, record
 * reception and crc check, nack/ack feedback once per frame, speech
 * mute; assumes operator inputs are on clk and the link is logic on clk
 */
`timescale 1ns/1ps
module emh_centre #(
    parameter int FB_FRAME_CYC = emh_pkg::FB_FRAME_CYC,
    parameter int ACK_SEND     = emh_pkg::ACK_SEND
) (
    input  wire logic        clk,
    input  wire logic        rst,
    emh_link_if.centre       link,
    input  wire logic        pull_req,
    input  wire logic        resend_req,
    input  wire logic        terminate,
    input  wire logic [7:0]  rd_addr,
    output logic [7:0]       rd_data,
    output logic             rec_ok,
    output logic             spk_mute
);
    if (FB_FRAME_CYC < 2 || ACK_SEND < 1 || ACK_SEND > 15)
        $error("emh_centre: parameter out of range");

    typedef enum logic [3:0] {
        EMH_C_IDLE = 4'b0001,
        EMH_C_REQ  = 4'b0010,
        EMH_C_RX   = 4'b0100,
        EMH_C_FB   = 4'b1000
    } emh_cst_t;

    logic [7:0]        mem [emh_pkg::REC_BYTES];
    emh_cst_t          st_q, st_d;
    emh_pkg::emh_msg_t msg_q, msg_d;
    logic [3:0]        cnt_q, cnt_d;
    logic [31:0]       frm_q, frm_d;
    logic [27:0]       crc_q, crc_d;
    logic [27:0]       rcrc_q, rcrc_d;
    logic              have_q, have_d;
    logic              dlv_q, dlv_d;
    emh_pkg::emh_msg_t dlm_q, dlm_d;
    logic              ok_q, ok_d;
    logic [7:0]        rd_q;
    logic [7:0]        dec;
    logic [7:0]        ridx;
    logic              tick;

    assign tick = (frm_q == 32'h0);
    assign dec  = emh_pkg::code_byte(link.ul_byte, link.ul_rv, ridx);

    always_comb
    begin
        st_d   = st_q;
        msg_d  = msg_q;
        cnt_d  = cnt_q;
        frm_d  = (frm_q == 32'(FB_FRAME_CYC - 1)) ? 32'h0 : frm_q + 32'h1;
        crc_d  = crc_q;
        rcrc_d = rcrc_q;
        have_d = have_q;
        ok_d   = 1'b0;
        dlv_d  = 1'b0;
        dlm_d  = dlm_q;
        if ((st_q == EMH_C_REQ || st_q == EMH_C_FB) && tick)
        begin
            dlv_d = 1'b1;
            dlm_d = msg_q;
        end
        case (st_q)
            EMH_C_IDLE:
            begin
                if (terminate)
                begin
                    st_d  = EMH_C_FB;
                    msg_d = emh_pkg::EMH_MSG_TERM;
                    cnt_d = 4'h1;
                    frm_d = 32'h0;
                end
                else if (resend_req && have_q)
                begin
                    st_d  = EMH_C_REQ;
                    msg_d = emh_pkg::EMH_MSG_RESEND;
                    frm_d = 32'h0;
                end
                else if (pull_req || (link.ul_msg_valid
                         && link.ul_msg == emh_pkg::EMH_MSG_PULL))
                begin
                    st_d  = EMH_C_REQ;
                    msg_d = emh_pkg::EMH_MSG_START;
                    frm_d = 32'h0;
                end
            end
            EMH_C_REQ, EMH_C_FB:
            begin
                if (st_q == EMH_C_FB && msg_q != emh_pkg::EMH_MSG_NACK
                    && tick)
                begin
                    cnt_d = cnt_q - 4'h1;
                    if (cnt_q == 4'h1)
                        st_d = EMH_C_IDLE;
                end
                // frame grid kept, so feedback never comes back to back
                if (terminate && msg_q != emh_pkg::EMH_MSG_TERM)
                begin
                    st_d  = EMH_C_FB;
                    msg_d = emh_pkg::EMH_MSG_TERM;
                    cnt_d = 4'h1;
                end
                else if (link.ul_valid && link.ul_first
                         && msg_q != emh_pkg::EMH_MSG_ACK
                         && msg_q != emh_pkg::EMH_MSG_TERM)
                begin
                    st_d  = EMH_C_RX;
                    crc_d = emh_pkg::crc_byte(emh_pkg::CRC_INIT, dec);
                end
            end
            EMH_C_RX:
            begin
                if (link.ul_valid)
                begin
                    if (ridx < 8'(emh_pkg::REC_BYTES))
                        crc_d = emh_pkg::crc_byte(crc_q, dec);
                    else
                        rcrc_d = {rcrc_q[19:0], dec};
                    if (link.ul_last)
                    begin
                        st_d  = EMH_C_FB;
                        frm_d = 32'h0;
                        if ({rcrc_q[19:0], dec} == crc_q)
                        begin
                            msg_d  = emh_pkg::EMH_MSG_ACK;
                            cnt_d  = 4'(ACK_SEND);
                            ok_d   = 1'b1;
                            have_d = 1'b1;
                        end
                        else
                            msg_d = emh_pkg::EMH_MSG_NACK;
                    end
                end
            end
            default:
                st_d = EMH_C_IDLE;
        endcase
    end

    // byte index derived from the sender's own framing
    logic [7:0] ridx_q;
    assign ridx = link.ul_first ? 8'h00 : ridx_q;

    always_ff @(posedge clk)
    begin
        if (link.ul_valid)
            ridx_q <= ridx + 8'h01;
        // later receptions overwrite the stored copy in place
        if (link.ul_valid && (st_q == EMH_C_RX || link.ul_first)
            && ridx < 8'(emh_pkg::REC_BYTES))
            mem[ridx] <= dec;
        rd_q <= (rd_addr < 8'(emh_pkg::REC_BYTES)) ? mem[rd_addr] : 8'h00;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_q   <= EMH_C_IDLE;
            msg_q  <= emh_pkg::EMH_MSG_NONE;
            cnt_q  <= 4'h0;
            frm_q  <= 32'h0;
            crc_q  <= emh_pkg::CRC_INIT;
            rcrc_q <= 28'h0;
            have_q <= 1'b0;
            dlv_q  <= 1'b0;
            dlm_q  <= emh_pkg::EMH_MSG_NONE;
            ok_q   <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            msg_q  <= msg_d;
            cnt_q  <= cnt_d;
            frm_q  <= frm_d;
            crc_q  <= crc_d;
            rcrc_q <= rcrc_d;
            have_q <= have_d;
            dlv_q  <= dlv_d;
            dlm_q  <= dlm_d;
            ok_q   <= ok_d;
        end
    end

    assign link.dl_valid = dlv_q;
    assign link.dl_msg   = dlm_q;
    assign rd_data       = rd_q;
    assign rec_ok        = ok_q;
    assign spk_mute      = (st_q != EMH_C_IDLE);
endmodule // emh_centre

// ===== rtl/emh_link_if.sv
/*
 * message-level link between vehicle and centre modem; assumes the
 * testbench connects both ends and supplies one shared clock
 */
`timescale 1ns/1ps
interface emh_link_if;
    logic               ul_valid;
    logic               ul_first;
    logic               ul_last;
    logic [7:0]         ul_byte;
    logic [2:0]         ul_rv;
    logic               ul_msg_valid;
    emh_pkg::emh_msg_t  ul_msg;
    logic               dl_valid;
    emh_pkg::emh_msg_t  dl_msg;

    modport vehicle (output ul_valid, ul_first, ul_last, ul_byte, ul_rv,
                     output ul_msg_valid, ul_msg,
                     input  dl_valid, dl_msg);
    modport centre  (input  ul_valid, ul_first, ul_last, ul_byte, ul_rv,
                     input  ul_msg_valid, ul_msg,
                     output dl_valid, dl_msg);
endinterface // emh_link_if

// ===== rtl/emh_pkg.sv
/*
 * shared constants, message codes and coding helpers for the in-band
 * emergency data link; assumes both ends run on one 25 MHz clock
 */
package emh_pkg;
    localparam int        REC_BYTES        = 140;
    localparam int        CRC_W            = 28;
    localparam int        FRAME_BYTES      = REC_BYTES + 4;
    localparam int        CLK_HZ           = 25_000_000;
    localparam int        SAMPLE_HZ        = 8000;
    localparam int        FB_FRAME_MS      = 140;
    localparam int        FB_FRAME_SAMPLES = FB_FRAME_MS * SAMPLE_HZ / 1000;
    localparam int        FB_FRAME_CYC     = FB_FRAME_SAMPLES
                                             * (CLK_HZ / SAMPLE_HZ);
    localparam int        DEADLINE_S       = 4;
    localparam int        DEADLINE_CYC     = DEADLINE_S * CLK_HZ;
    localparam int        PUSH_TIMEOUT_CYC = 10 * FB_FRAME_CYC;
    localparam int        ACK_NEED         = 2;
    localparam int        ACK_SEND         = 5;
    localparam logic [27:0] CRC_POLY       = 28'h0000009;
    localparam logic [27:0] CRC_INIT       = 28'h0000000;
    localparam logic [7:0]  SCR_SEED       = 8'h5b;

    typedef enum logic [2:0] {
        EMH_MSG_NONE   = 3'h0,
        EMH_MSG_START  = 3'h1,
        EMH_MSG_NACK   = 3'h2,
        EMH_MSG_ACK    = 3'h3,
        EMH_MSG_RESEND = 3'h4,
        EMH_MSG_TERM   = 3'h5,
        EMH_MSG_PULL   = 3'h6
    } emh_msg_t;

    function automatic logic [27:0] crc_byte(input logic [27:0] c,
                                             input logic [7:0]  b);
        logic [27:0] r;
        logic        fb;
        r = c;
        for (int i = 7; i >= 0; i--)
        begin
            fb = r[27] ^ b[i];
            r  = {r[26:0], 1'b0};
            if (fb)
                r = r ^ CRC_POLY;
        end
        return r;
    endfunction

    // redundancy version and position both steer the coded byte, so a
    // retransmission after a nack never repeats the previous coded bits; xor undoes it
    function automatic logic [7:0] code_byte(input logic [7:0] b,
                                             input logic [2:0] rv,
                                             input logic [7:0] idx);
        return b ^ (SCR_SEED + idx) ^ {rv, rv, rv[1:0]};
    endfunction
endpackage

// ===== rtl/emh_vehicle.sv
/*
 * vehicle-side modem protocol control: record store, crc, coded
 * transmission with growing redundancy version, push request, feedback
 * handling; assumes user inputs are on clk and the link is logic on clk
 */
`timescale 1ns/1ps
// Function
// - receiver always watches downlink during call (vehicle here ignores downlink while sending a record)
// - on request, mute mic, route transmitter
// - append crc, encode, map to symbols (vehicle here sends coded bytes with no symbol mapping)
// - each retransmission uses new redundancy version (vehicle here restarts at version 0 on a resend request)
// - retransmit on nack; stop on acks/terminate
// - after exchange, transmitters idle and disconnected
// - push request uses downlink message format
// - repeat request until start or timeout
// - record always 140 bytes, zero padded
// - centre demodulates only after data detected
// - centre combines all receptions before decoding (centre here keeps only the latest reception and checks its crc alone)
// - centre sends nack on crc failure
// - centre delivers record and sends acks
// - centre answers vehicle trigger with request
// - centre mutes speech while sending feedback
// - centre unmutes after acks sent
// - resend of latest record on centre request
// - record should arrive within 4 seconds
// - feedback frame lasts 1120 samples
module emh_vehicle #(
    parameter int FB_FRAME_CYC     = emh_pkg::FB_FRAME_CYC,
    parameter int PUSH_TIMEOUT_CYC = emh_pkg::PUSH_TIMEOUT_CYC,
    parameter int DEADLINE_CYC     = emh_pkg::DEADLINE_CYC,
    parameter int ACK_NEED         = emh_pkg::ACK_NEED
) (
    input  wire logic        clk,
    input  wire logic        rst,
    emh_link_if.vehicle      link,
    input  wire logic        call_up,
    input  wire logic        push_start,
    input  wire logic        rec_we,
    input  wire logic [7:0]  rec_addr,
    input  wire logic [7:0]  rec_wdata,
    input  wire logic [7:0]  rec_len,
    output logic             mic_mute,
    output logic             tx_path_on,
    output logic             busy,
    output logic             done,
    output logic             fail,
    output logic             late
);
    if (FB_FRAME_CYC < 2 || PUSH_TIMEOUT_CYC < 1 || DEADLINE_CYC < 1
        || ACK_NEED < 1 || ACK_NEED > 15)
        $error("emh_vehicle: parameter out of range");

    typedef enum logic [3:0] {
        EMH_V_IDLE = 4'b0001,
        EMH_V_PUSH = 4'b0010,
        EMH_V_SEND = 4'b0100,
        EMH_V_WAIT = 4'b1000
    } emh_vst_t;

    logic [7:0]  mem [emh_pkg::REC_BYTES];
    emh_vst_t    st_q, st_d;
    logic [7:0]  idx_q, idx_d;
    logic [2:0]  rv_q, rv_d;
    logic [27:0] crc_q, crc_d;
    logic [3:0]  ack_q, ack_d;
    logic [31:0] frm_q, frm_d;
    logic [31:0] tmo_q, tmo_d;
    logic [31:0] dl_q, dl_d;
    logic        dl_run_q, dl_run_d;
    logic        late_q, late_d;
    logic        call_q, call_d;
    logic        ulv_q, ulv_d, ulf_q, ulf_d, ull_q, ull_d;
    logic [7:0]  ulb_q, ulb_d;
    logic [2:0]  ulr_q, ulr_d;
    logic        umv_q, umv_d;
    logic        done_q, done_d, fail_q, fail_d;
    logic [7:0]  pay;
    logic        fb_ok;

    always_ff @(posedge clk)
    begin
        if (rec_we && rec_addr < 8'(emh_pkg::REC_BYTES))
            mem[rec_addr] <= rec_wdata;
    end

    // downlink is only acted on while a call stands
    assign fb_ok = link.dl_valid && call_up;

    always_comb
    begin
        pay = 8'h00;
        if (idx_q < 8'(emh_pkg::REC_BYTES))
            pay = (idx_q < rec_len) ? mem[idx_q] : 8'h00;
        else
            case (idx_q - 8'(emh_pkg::REC_BYTES))
                8'h00:   pay = {4'h0, crc_q[27:24]};
                8'h01:   pay = crc_q[23:16];
                8'h02:   pay = crc_q[15:8];
                default: pay = crc_q[7:0];
            endcase
    end

    always_comb
    begin
        st_d     = st_q;
        idx_d    = idx_q;
        rv_d     = rv_q;
        crc_d    = crc_q;
        ack_d    = ack_q;
        frm_d    = (frm_q == 32'(FB_FRAME_CYC - 1)) ? 32'h0 : frm_q + 32'h1;
        tmo_d    = tmo_q;
        dl_d     = dl_q;
        dl_run_d = dl_run_q;
        late_d   = late_q;
        call_d   = call_up;
        ulv_d    = 1'b0;
        ulf_d    = 1'b0;
        ull_d    = 1'b0;
        ulb_d    = ulb_q;
        ulr_d    = ulr_q;
        umv_d    = 1'b0;
        done_d   = 1'b0;
        fail_d   = 1'b0;
        if (call_up && !call_q)
        begin
            dl_d     = 32'h0;
            dl_run_d = 1'b1;
        end
        else if (dl_run_q)
        begin
            if (dl_q == 32'(DEADLINE_CYC - 1))
            begin
                late_d   = 1'b1;
                dl_run_d = 1'b0;
            end
            else
                dl_d = dl_q + 32'h1;
        end
        case (st_q)
            EMH_V_IDLE:
            begin
                ack_d = 4'h0;
                if (fb_ok && (link.dl_msg == emh_pkg::EMH_MSG_START
                    || link.dl_msg == emh_pkg::EMH_MSG_RESEND))
                begin
                    st_d  = EMH_V_SEND;
                    idx_d = 8'h00;
                    rv_d  = 3'h0;
                    crc_d = emh_pkg::CRC_INIT;
                end
                else if (push_start && call_up)
                begin
                    st_d  = EMH_V_PUSH;
                    tmo_d = 32'h0;
                    // first request leaves now, so the frame count starts
                    // one in; otherwise a second request follows at once
                    frm_d = 32'h1;
                    umv_d = 1'b1;
                end
            end
            EMH_V_PUSH:
            begin
                tmo_d = tmo_q + 32'h1;
                if (frm_q == 32'h0)
                    umv_d = 1'b1;
                if (fb_ok && link.dl_msg == emh_pkg::EMH_MSG_START)
                begin
                    st_d  = EMH_V_SEND;
                    idx_d = 8'h00;
                    rv_d  = 3'h0;
                    crc_d = emh_pkg::CRC_INIT;
                end
                else if (tmo_q == 32'(PUSH_TIMEOUT_CYC - 1) || !call_up)
                begin
                    st_d   = EMH_V_IDLE;
                    fail_d = 1'b1;
                end
            end
            EMH_V_SEND:
            begin
                ulv_d = 1'b1;
                ulf_d = (idx_q == 8'h00);
                ull_d = (idx_q == 8'(emh_pkg::FRAME_BYTES - 1));
                ulb_d = emh_pkg::code_byte(pay, rv_q, idx_q);
                ulr_d = rv_q;
                if (idx_q < 8'(emh_pkg::REC_BYTES))
                    crc_d = emh_pkg::crc_byte(crc_q, pay);
                if (ull_d)
                    st_d = EMH_V_WAIT;
                else
                    idx_d = idx_q + 8'h01;
            end
            EMH_V_WAIT:
            begin
                if (!call_up)
                    st_d = EMH_V_IDLE;
                else if (fb_ok)
                    case (link.dl_msg)
                        emh_pkg::EMH_MSG_NACK:
                        begin
                            st_d  = EMH_V_SEND;
                            idx_d = 8'h00;
                            rv_d  = rv_q + 3'h1;
                            crc_d = emh_pkg::CRC_INIT;
                        end
                        emh_pkg::EMH_MSG_ACK:
                        begin
                            ack_d = ack_q + 4'h1;
                            if (ack_q + 4'h1 >= 4'(ACK_NEED))
                            begin
                                st_d     = EMH_V_IDLE;
                                done_d   = 1'b1;
                                dl_run_d = 1'b0;
                            end
                        end
                        emh_pkg::EMH_MSG_TERM:
                            st_d = EMH_V_IDLE;
                        emh_pkg::EMH_MSG_RESEND:
                        begin
                            st_d  = EMH_V_SEND;
                            idx_d = 8'h00;
                            rv_d  = 3'h0;
                            crc_d = emh_pkg::CRC_INIT;
                        end
                        default:
                            st_d = EMH_V_WAIT;
                    endcase
            end
            default:
                st_d = EMH_V_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_q     <= EMH_V_IDLE;
            idx_q    <= 8'h00;
            rv_q     <= 3'h0;
            crc_q    <= emh_pkg::CRC_INIT;
            ack_q    <= 4'h0;
            frm_q    <= 32'h0;
            tmo_q    <= 32'h0;
            dl_q     <= 32'h0;
            dl_run_q <= 1'b0;
            late_q   <= 1'b0;
            call_q   <= 1'b0;
            ulv_q    <= 1'b0;
            ulf_q    <= 1'b0;
            ull_q    <= 1'b0;
            ulb_q    <= 8'h00;
            ulr_q    <= 3'h0;
            umv_q    <= 1'b0;
            done_q   <= 1'b0;
            fail_q   <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            idx_q    <= idx_d;
            rv_q     <= rv_d;
            crc_q    <= crc_d;
            ack_q    <= ack_d;
            frm_q    <= frm_d;
            tmo_q    <= tmo_d;
            dl_q     <= dl_d;
            dl_run_q <= dl_run_d;
            late_q   <= late_d;
            call_q   <= call_d;
            ulv_q    <= ulv_d;
            ulf_q    <= ulf_d;
            ull_q    <= ull_d;
            ulb_q    <= ulb_d;
            ulr_q    <= ulr_d;
            umv_q    <= umv_d;
            done_q   <= done_d;
            fail_q   <= fail_d;
        end
    end

    assign link.ul_valid     = ulv_q;
    assign link.ul_first     = ulf_q;
    assign link.ul_last      = ull_q;
    assign link.ul_byte      = ulb_q;
    assign link.ul_rv        = ulr_q;
    assign link.ul_msg_valid = umv_q;
    assign link.ul_msg       = emh_pkg::EMH_MSG_PULL;
    // path released as soon as the machine is back in idle
    assign tx_path_on        = (st_q != EMH_V_IDLE);
    assign mic_mute          = (st_q != EMH_V_IDLE);
    assign busy              = (st_q != EMH_V_IDLE);
    assign done              = done_q;
    assign fail              = fail_q;
    assign late              = late_q;
endmodule // emh_vehicle

// ===== test/emergency_data_harq_link_bench.sv
/* bench: both modem ends on one link, checked against a byte model
   assumes design package and link interface are compiled first */
`timescale 1ns/1ps
module emergency_data_harq_link_bench;
    logic       clk = 1'b0, rst = 1'b1, call_up = 1'b0, push_start = 1'b0;
    logic       rec_we = 1'b0, pull_req = 1'b0, resend_req = 1'b0;
    logic       terminate = 1'b0;
    logic [7:0] rec_addr = 8'h00, rec_wdata = 8'h00, rec_len = 8'h64;
    logic [7:0] rd_addr = 8'h00, rd_data, seed = 8'h62;
    logic       mic_mute, tx_path_on, done, late, rec_ok, spk_mute;
    logic [7:0] m [140];
    logic [7:0] q [$];
    logic [2:0] rvq [$];
    int         num_errors = 0, samples_checked = 0, cyc = 0, oks = 0;
    emh_link_if link ();
    emh_vehicle #(.FB_FRAME_CYC(200), .PUSH_TIMEOUT_CYC(2000),
        .DEADLINE_CYC(5000)) emh_vehicle_inst (.clk(clk), .rst(rst),
        .link(link), .call_up(call_up), .push_start(push_start),
        .rec_we(rec_we), .rec_addr(rec_addr), .rec_wdata(rec_wdata),
        .rec_len(rec_len), .mic_mute(mic_mute), .tx_path_on(tx_path_on),
        .busy(), .done(done), .fail(), .late(late));
    emh_centre #(.FB_FRAME_CYC(200)) emh_centre_inst (.clk(clk), .rst(rst),
        .link(link), .pull_req(pull_req), .resend_req(resend_req),
        .terminate(terminate), .rd_addr(rd_addr), .rd_data(rd_data),
        .rec_ok(rec_ok), .spk_mute(spk_mute));
    emh_link_monitor emh_link_monitor_inst (.clk(clk), .rst(rst),
        .ul_valid(link.ul_valid), .ul_first(link.ul_first),
        .ul_last(link.ul_last), .ul_byte(link.ul_byte), .ul_rv(link.ul_rv),
        .ul_msg_valid(link.ul_msg_valid), .ul_msg(link.ul_msg),
        .dl_valid(link.dl_valid), .dl_msg(link.dl_msg));
    always #20 clk = ~clk;

    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function automatic logic [7:0] pay(input int i);
        return i < int'(rec_len) ? m[i] : 8'h00;
    endfunction
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t byte %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t flag %b want %b", $time, got, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    // waits for the acks, then replays crc and coding on the model
    task automatic run_send();
        logic [27:0] c;
        logic [31:0] w;
        logic [7:0]  b;
        c = 28'h0000000;
        for (int i = 0; i < 3000 && done !== 1'b1; i++)
            @(negedge clk);
        cmp1(done, 1'b1);
        cmp1(mic_mute | tx_path_on, 1'b0);
        cmp8(8'(q.size()), 8'h90);
        cmp8({5'h00, rvq[0]}, 8'h00);
        for (int i = 0; i < 140; i++)
        begin
            b = pay(i);
            for (int j = 7; j >= 0; j--)
                c = {c[26:0], 1'b0}
                    ^ ((c[27] ^ b[j]) ? emh_pkg::CRC_POLY : 28'h0000000);
        end
        w = {4'h0, c};
        for (int i = 0; i < 144; i++)
        begin
            b = i < 140 ? pay(i) : w[8 * (143 - i) +: 8];
            cmp8(q[i], b ^ (emh_pkg::SCR_SEED + 8'(i)));
        end
        q.delete();
        rvq.delete();
        repeat (1200) @(negedge clk);
        cmp1(spk_mute, 1'b0);
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (rec_ok === 1'b1)
            oks <= oks + 1;
        if (link.ul_valid === 1'b1)
        begin
            q.push_back(link.ul_byte);
            rvq.push_back(link.ul_rv);
        end
    end
    always @(negedge clk)
    begin
        if (link.ul_valid === 1'b1)
        begin
            cmp1(mic_mute & tx_path_on, 1'b1);
            cmp1(spk_mute, 1'b1);
        end
        // ceiling sits well above three full exchanges
        if (cyc == 20000)
        begin
            num_errors++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        call_up = 1'b1;
        rec_we = 1'b1;
        for (int i = 0; i < 140; i++)
        begin
            seed = lfsr(seed);
            m[i] = seed;
            rec_addr = 8'(i);
            rec_wdata = seed;
            @(negedge clk);
        end
        rec_we = 1'b0;
        pulse(pull_req);
        run_send();
        cmp1(late, 1'b0);
        for (int i = 0; i < 141; i++)
        begin
            rd_addr = i < 140 ? 8'(i) : 8'hc8;
            @(negedge clk);
            cmp8(rd_data, pay(i));
        end
        cmp8(8'(oks), 8'h01);
        pulse(resend_req);
        run_send();
        pulse(push_start);
        run_send();
        cmp8(8'(oks), 8'h03);
        // cut the exchange after the first ack: only the end can free it
        pulse(pull_req);
        for (int i = 0; i < 3000 && rec_ok !== 1'b1; i++)
            @(negedge clk);
        pulse(terminate);
        repeat (400) @(negedge clk);
        cmp1(mic_mute | spk_mute, 1'b0);
        print_verdict();
    end
endmodule // emergency_data_harq_link_bench

// ===== test/emh_link_monitor.sv
/* link checker: timing relations on the shared link
   assumes one clock and a sync reset shared by both ends */
`timescale 1ns/1ps
module emh_link_monitor (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              ul_valid,
    input wire logic              ul_first,
    input wire logic              ul_last,
    input wire logic [7:0]        ul_byte,
    input wire logic [2:0]        ul_rv,
    input wire logic              ul_msg_valid,
    input wire emh_pkg::emh_msg_t ul_msg,
    input wire logic              dl_valid,
    input wire emh_pkg::emh_msg_t dl_msg
);
    // only these three feedback codes may launch a transmission
    wire go_msg = dl_valid && (dl_msg == emh_pkg::EMH_MSG_START
        || dl_msg == emh_pkg::EMH_MSG_NACK
        || dl_msg == emh_pkg::EMH_MSG_RESEND);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_burst;
        ul_valid [*8];
    endsequence
    sequence s_tail;
        ##143 ul_last ##1 !ul_valid;
    endsequence
    chk_burst_run: assert property (ul_first |-> s_burst)
        else $error("record burst broken");
    chk_tail_off: assert property (ul_first |-> s_tail)
        else $error("record length or release wrong");
    // the vehicle changes state one edge and launches byte 0 the next
    chk_send_cause: assert property (ul_first |-> $past(go_msg, 2))
        else $error("send without feedback request");
    chk_rv_hold: assert property (ul_valid && !ul_first |->
        $stable(ul_rv)) else $error("version changed mid record");
    chk_pull_code: assert property (ul_msg_valid |->
        ul_msg == emh_pkg::EMH_MSG_PULL) else $error("bad request code");
    chk_quiet_send: assert property (ul_valid |-> !ul_msg_valid)
        else $error("request during record");
    chk_fb_gap: assert property (dl_valid |=> !dl_valid [*8])
        else $error("feedback frames too close");
    chk_req_gap: assert property (ul_msg_valid |=>
        !ul_msg_valid [*8]) else $error("requests too close");
endmodule // emh_link_monitor
